// ==== hdl/ead_pkg.sv ====
`default_nettype none
package ead_pkg;

	// physical address field that picks the area
	localparam int AREA_HI = 28;
	localparam int AREA_LO = 26;
	localparam int CARD_IO_BIT = 25;
	localparam int OFFSET_W = 26;
	localparam int NUM_AREAS = 7;

	localparam logic [2:0] AREA_0 = 3'h0;
	localparam logic [2:0] AREA_1 = 3'h1;
	localparam logic [2:0] AREA_2 = 3'h2;
	localparam logic [2:0] AREA_3 = 3'h3;
	localparam logic [2:0] AREA_4 = 3'h4;
	localparam logic [2:0] AREA_5 = 3'h5;
	localparam logic [2:0] AREA_6 = 3'h6;
	localparam logic [2:0] AREA_INTERNAL = 3'h7;

	// bus width codes: width bytes = 1 << (code - 1)
	localparam logic [1:0] WID_RSV = 2'h0;
	localparam logic [1:0] WID_8 = 2'h1;
	localparam logic [1:0] WID_16 = 2'h2;
	localparam logic [1:0] WID_32 = 2'h3;

	// access size codes; a line is a 16-byte burst
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [1:0] SZ_LINE = 2'h3;
	localparam logic [2:0] LINE_LOG = 3'h4;

	// memory kind of areas 2 and 3
	localparam logic [1:0] MEM_NORMAL = 2'h0;
	localparam logic [1:0] MEM_DRAM = 2'h1;
	localparam logic [1:0] MEM_SDRAM = 2'h2;
	localparam logic [1:0] MEM_PSRAM = 2'h3;

	// three-bit wait code to wait cycles, 0 to 10
	localparam logic [3:0] WAIT_LUT [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA};
	localparam logic [3:0] BEAT_BASE = 4'h2;
	localparam int BURST_PITCH_MIN = 2;
	localparam int BURST_PITCH_MAX = 10;
	localparam logic [4:0] ROW_SHIFT_BASE = 5'h08;

	typedef enum logic [5:0] {
		EAD_IDLE = 6'h01,
		EAD_SETUP = 6'h02,
		EAD_T1 = 6'h04,
		EAD_TW = 6'h08,
		EAD_T2 = 6'h10,
		EAD_HOLD = 6'h20
	} ead_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic [1:0] size;
	} ead_req_t;

	typedef struct packed {
		logic [2:0] area0_wait_count;
		logic [1:0] area12_wait_count;
		logic [1:0] area3_wait_count;
		logic [2:0] area4_wait_count;
		logic [2:0] area5_wait_count;
		logic [2:0] area6_wait_count;
		logic [1:0] area1_width_sel;
		logic [1:0] area2_width_sel;
		logic [1:0] area3_width_sel;
		logic [1:0] area4_width_sel;
		logic [1:0] area5_width_sel;
		logic [1:0] area6_width_sel;
		logic [1:0] area2_type;
		logic [1:0] area3_type;
		logic area5_card;
		logic area6_card;
		logic area0_burst_rom;
		logic area5_burst_rom;
		logic area6_burst_rom;
		logic memctl_size_bit;
		logic [1:0] area2_amx;
		logic [1:0] area3_amx;
		logic [1:0] area5_setup_delay;
		logic [1:0] area5_hold_delay;
		logic [1:0] area6_setup_delay;
		logic [1:0] area6_hold_delay;
	} ead_cfg_t;

	typedef struct packed {
		logic [6:0] area_select_n;
		logic read_strobe_n;
		logic [3:0] byte_write_strobe_n;
		logic rd_wr;
		logic area2_row_strobe_n;
		logic area2_col_strobe_hi_n;
		logic area2_col_strobe_lo_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic [3:0] col_strobe_byte_n;
		logic [3:0] byte_mask;
		logic output_enable_refresh_n;
		logic card_enable_low_n;
		logic card_enable_high_n;
		logic area6_card_enable_low_n;
		logic area6_card_enable_high_n;
		logic card_oe_n;
		logic card_we_n;
		logic card_io_read_n;
		logic card_io_write_n;
	} ead_strobe_t;

endpackage
`default_nettype wire

// ==== hdl/ead_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module ead_decoder
	import ead_pkg::*;
#(
	parameter int BURST_MIN_PITCH = BURST_PITCH_MIN
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire ead_req_t REQ,
	input wire ead_cfg_t CFG,
	input wire logic BOOT_WIDTH_PIN_A,
	input wire logic BOOT_WIDTH_PIN_B,
	input wire logic WAIT_N,
	output ead_strobe_t STROBES,
	output logic [OFFSET_W-1:0] BUS_ADDR,
	output logic [1:0] BUS_WIDTH,
	output logic BEAT_DONE,
	output logic XFER_DONE,
	output logic RANGE_FAULT
);

	if (BURST_MIN_PITCH < BURST_PITCH_MIN || BURST_MIN_PITCH > BURST_PITCH_MAX) begin : g_chk
		$error("burst pitch minimum out of range");
	end

	function automatic logic f_card(input logic [2:0] a, input ead_cfg_t c);
		return (a == AREA_5 && c.area5_card) || (a == AREA_6 && c.area6_card);
	endfunction

	function automatic logic [1:0] f_type(input logic [2:0] a, input ead_cfg_t c);
		logic [1:0] t;
		t = MEM_NORMAL;
		if (a == AREA_2) begin
			t = c.area2_type;
		end else if (a == AREA_3) begin
			t = c.area3_type;
		end
		return t;
	endfunction

	function automatic logic [1:0] f_width(input logic [2:0] a, input ead_cfg_t c,
		input logic [1:0] boot);
		logic [1:0] w;
		logic [1:0] big;
		big = c.memctl_size_bit ? WID_32 : WID_16;
		case (a)
			AREA_0: w = boot;
			AREA_1: w = c.area1_width_sel;
			AREA_2: w = (c.area2_type == MEM_NORMAL) ? c.area2_width_sel :
				(c.area2_type == MEM_DRAM) ? WID_16 : big;
			AREA_3: w = (c.area2_type == MEM_DRAM) ? WID_16 :
				(c.area3_type == MEM_NORMAL) ? c.area3_width_sel : big;
			AREA_4: w = c.area4_width_sel;
			AREA_5: w = c.area5_width_sel;
			AREA_6: w = c.area6_width_sel;
			default: w = WID_32;
		endcase
		if (w == WID_RSV) begin
			w = WID_32;
		end
		if (f_card(a, c) && w == WID_32) begin
			w = WID_16;
		end
		return w;
	endfunction

	function automatic logic [3:0] f_waits(input logic [2:0] a, input ead_cfg_t c);
		logic [3:0] n;
		case (a)
			AREA_0: n = WAIT_LUT[c.area0_wait_count];
			AREA_1, AREA_2: n = {2'h0, c.area12_wait_count};
			AREA_3: n = {2'h0, c.area3_wait_count};
			AREA_4: n = WAIT_LUT[c.area4_wait_count];
			AREA_5: n = WAIT_LUT[c.area5_wait_count];
			AREA_6: n = WAIT_LUT[c.area6_wait_count];
			default: n = 4'h0;
		endcase
		return n;
	endfunction

	function automatic logic f_burst_rom(input logic [2:0] a, input ead_cfg_t c);
		return (a == AREA_0 && c.area0_burst_rom) ||
			(a == AREA_5 && c.area5_burst_rom && !c.area5_card) ||
			(a == AREA_6 && c.area6_burst_rom && !c.area6_card);
	endfunction

	function automatic logic [2:0] f_size_log(input logic [1:0] s);
		return (s == SZ_LINE) ? LINE_LOG : {1'b0, s};
	endfunction

	// beats needed minus one when the access is wider than the port
	function automatic logic [3:0] f_beats(input logic [1:0] s, input logic [1:0] w);
		logic [2:0] bl;
		logic [2:0] wl;
		logic [4:0] n;
		bl = f_size_log(s);
		wl = {1'b0, w} - 3'h1;
		n = 5'h00;
		if (bl > wl) begin
			n = (5'h01 << (bl - wl)) - 5'h01;
		end
		return n[3:0];
	endfunction

	// byte lanes of one beat; an 8-bit port always lands on lane 0
	function automatic logic [3:0] f_lanes(input logic [1:0] s, input logic [1:0] w,
		input logic [1:0] ad);
		logic [2:0] bl;
		logic [2:0] wl;
		logic [2:0] nb;
		logic [2:0] base;
		logic [7:0] m;
		bl = f_size_log(s);
		wl = {1'b0, w} - 3'h1;
		if (bl > wl) begin
			bl = wl;
		end
		nb = 3'h1 << bl;
		base = {1'b0, ad} & ((3'h1 << wl) - 3'h1) & ~(nb - 3'h1);
		m = ((8'h01 << nb) - 8'h01) << base;
		return m[3:0];
	endfunction

	function automatic logic f_dram_kind(input logic [2:0] a, input ead_cfg_t c);
		logic [1:0] t;
		t = f_type(a, c);
		return t == MEM_DRAM || t == MEM_SDRAM;
	endfunction

	ead_state_t st, next_st;
	logic [2:0] area, next_area;
	logic [OFFSET_W-1:0] addr, next_addr;
	logic [OFFSET_W-1:0] next_bus_addr;
	logic write, next_write;
	logic [1:0] size, next_size;
	logic [1:0] width, next_width;
	logic [3:0] beats, next_beats;
	logic [3:0] waits, next_waits;
	logic [1:0] cnt, next_cnt;
	logic io_cyc, next_io_cyc;
	logic next_beat_done, next_xfer_done, next_fault;
	logic [1:0] boot_width;
	logic [2:0] req_area;
	logic wait_ok;
	logic [3:0] pitch_w;
	logic [3:0] burst_w;

	assign req_area = REQ.addr[AREA_HI:AREA_LO];
	assign wait_ok = f_type(area, CFG) == MEM_NORMAL;
	assign pitch_w = (f_waits(area, CFG) > 4'(BURST_MIN_PITCH)) ?
		f_waits(area, CFG) : 4'(BURST_MIN_PITCH);
	assign burst_w = pitch_w - BEAT_BASE;
	assign REQ_READY = st == EAD_IDLE;

	// mode pins are caught while reset is held
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			boot_width <= {BOOT_WIDTH_PIN_B, BOOT_WIDTH_PIN_A};
		end
	end

	always_comb begin
		next_st = st;
		next_area = area;
		next_addr = addr;
		next_write = write;
		next_size = size;
		next_width = width;
		next_beats = beats;
		next_waits = waits;
		next_cnt = cnt;
		next_io_cyc = io_cyc;
		next_beat_done = 1'b0;
		next_xfer_done = 1'b0;
		next_fault = 1'b0;
		unique case (st)
			EAD_IDLE: begin
				if (REQ_VALID) begin
					next_area = req_area;
					next_addr = REQ.addr[OFFSET_W-1:0];
					next_write = REQ.write;
					next_size = REQ.size;
					next_width = f_width(req_area, CFG, boot_width);
					next_beats = f_beats(REQ.size, next_width);
					next_waits = f_waits(req_area, CFG);
					next_io_cyc = req_area == AREA_6 && CFG.area6_card &&
						REQ.addr[CARD_IO_BIT];
					if (req_area == AREA_INTERNAL) begin
						next_xfer_done = 1'b1;
					end else if (req_area == AREA_5 && CFG.area5_card &&
						REQ.addr[CARD_IO_BIT]) begin
						next_xfer_done = 1'b1;
						next_fault = 1'b1;
					end else if (f_card(req_area, CFG)) begin
						next_st = EAD_SETUP;
						next_cnt = (req_area == AREA_5) ? CFG.area5_setup_delay :
							CFG.area6_setup_delay;
					end else begin
						next_st = EAD_T1;
					end
				end
			end
			EAD_SETUP: begin
				if (cnt == 2'h0) begin
					next_st = EAD_T1;
				end else begin
					next_cnt = cnt - 2'h1;
				end
			end
			EAD_T1: begin
				next_st = (waits == 4'h0) ? EAD_T2 : EAD_TW;
			end
			EAD_TW: begin
				if (waits > 4'h1) begin
					next_waits = waits - 4'h1;
				end else if (!(wait_ok && !WAIT_N)) begin
					next_st = EAD_T2;
				end
			end
			EAD_T2: begin
				next_beat_done = 1'b1;
				if (beats != 4'h0) begin
					next_beats = beats - 4'h1;
					next_addr = addr + (OFFSET_W'(1) << (width - 2'h1));
					next_waits = (f_burst_rom(area, CFG) && size == SZ_LINE) ?
						burst_w : f_waits(area, CFG);
					next_st = EAD_T1;
				end else if (f_card(area, CFG)) begin
					next_st = EAD_HOLD;
					next_cnt = (area == AREA_5) ? CFG.area5_hold_delay :
						CFG.area6_hold_delay;
				end else begin
					next_st = EAD_IDLE;
					next_xfer_done = 1'b1;
				end
			end
			EAD_HOLD: begin
				if (cnt == 2'h0) begin
					next_st = EAD_IDLE;
					next_xfer_done = 1'b1;
				end else begin
					next_cnt = cnt - 2'h1;
				end
			end
			default: begin
				next_st = EAD_IDLE;
			end
		endcase
		// row address on A15..A1 for the first cycle of a DRAM beat
		next_bus_addr = next_addr;
		if (next_st == EAD_T1 && f_dram_kind(next_area, CFG)) begin
			next_bus_addr[15:1] = 15'(next_addr >> (ROW_SHIFT_BASE +
				{3'h0, (next_area == AREA_2 && CFG.area2_type == MEM_DRAM) ?
				CFG.area2_amx : CFG.area3_amx}));
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st <= EAD_IDLE;
			area <= AREA_0;
			addr <= '0;
			write <= 1'b0;
			size <= SZ_BYTE;
			width <= WID_32;
			beats <= 4'h0;
			waits <= 4'h0;
			cnt <= 2'h0;
			io_cyc <= 1'b0;
			BUS_ADDR <= '0;
			BEAT_DONE <= 1'b0;
			XFER_DONE <= 1'b0;
			RANGE_FAULT <= 1'b0;
		end else begin
			st <= next_st;
			area <= next_area;
			addr <= next_addr;
			write <= next_write;
			size <= next_size;
			width <= next_width;
			beats <= next_beats;
			waits <= next_waits;
			cnt <= next_cnt;
			io_cyc <= next_io_cyc;
			BUS_ADDR <= next_bus_addr;
			BEAT_DONE <= next_beat_done;
			XFER_DONE <= next_xfer_done;
			RANGE_FAULT <= next_fault;
		end
	end

	assign BUS_WIDTH = width;

	logic act, cyc, card, rd, wr, col_ph;
	logic [1:0] mtype;
	logic [3:0] lanes;
	logic [6:0] sel_n;

	assign act = st == EAD_T1 || st == EAD_TW || st == EAD_T2;
	assign cyc = act || st == EAD_SETUP || st == EAD_HOLD;
	assign col_ph = st == EAD_TW || st == EAD_T2;
	assign card = f_card(area, CFG);
	assign mtype = f_type(area, CFG);
	assign rd = act && !write;
	assign wr = act && write;
	assign lanes = f_lanes(size, width, addr[1:0]);

	for (genvar i = 0; i < NUM_AREAS; i++) begin : g_sel
		assign sel_n[i] = !(act && area == 3'(i) && !card);
	end

	always_comb begin
		STROBES = '1;
		STROBES.rd_wr = !wr;
		STROBES.byte_mask = 4'h0;
		STROBES.area_select_n = sel_n;
		if (!card && mtype == MEM_NORMAL) begin
			STROBES.read_strobe_n = !rd;
			STROBES.byte_write_strobe_n = ~(lanes & {4{wr}});
		end
		if (mtype == MEM_PSRAM) begin
			STROBES.output_enable_refresh_n = !rd;
			STROBES.byte_write_strobe_n = ~(lanes & {4{wr}});
		end
		if (mtype == MEM_DRAM && area == AREA_2) begin
			STROBES.area2_row_strobe_n = !act;
			STROBES.area2_col_strobe_hi_n = !(col_ph && lanes[1]);
			STROBES.area2_col_strobe_lo_n = !(col_ph && lanes[0]);
		end
		if (mtype == MEM_DRAM && area == AREA_3) begin
			STROBES.row_strobe_n = !act;
			STROBES.col_strobe_byte_n = ~(lanes & {4{col_ph}});
		end
		if (mtype == MEM_SDRAM) begin
			STROBES.row_strobe_n = !(st == EAD_T1);
			STROBES.col_strobe_n = !col_ph;
			STROBES.byte_mask = ~lanes & {4{act}};
		end
		if (card && area == AREA_5) begin
			STROBES.card_enable_low_n = !cyc;
			STROBES.card_enable_high_n = !cyc;
			STROBES.card_oe_n = !rd;
			STROBES.card_we_n = !wr;
		end
		if (card && area == AREA_6) begin
			STROBES.area6_card_enable_low_n = !cyc;
			STROBES.area6_card_enable_high_n = !cyc;
			STROBES.card_oe_n = !(rd && !io_cyc);
			STROBES.byte_write_strobe_n[1] = !(wr && !io_cyc);
			STROBES.card_io_read_n = !(rd && io_cyc);
			STROBES.card_io_write_n = !(wr && io_cyc);
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	sequence s_take;
		st == EAD_IDLE && REQ_VALID;
	endsequence

	sequence s_last_wait;
		st == EAD_TW && waits == 4'h1;
	endsequence

	a_area_decode: assert property (s_take |=> area == $past(REQ.addr[AREA_HI:AREA_LO]))
		else $error("area not taken from address bits");
	a_internal_quiet: assert property (area == AREA_INTERNAL |-> sel_n == 7'h7F &&
		STROBES.read_strobe_n && STROBES.byte_write_strobe_n == 4'hF)
		else $error("strobe on internal region");
	a_boot_width: assert property (act && area == AREA_0 && boot_width != WID_RSV |->
		width == boot_width)
		else $error("area 0 width not from boot pins");
	a_area0_select: assert property (rd && area == AREA_0 |->
		!STROBES.area_select_n[0] && !STROBES.read_strobe_n)
		else $error("area 0 read without select");
	a_zero_wait: assert property (st == EAD_T1 && waits == 4'h0 |=> st == EAD_T2)
		else $error("zero-wait beat not two cycles");
	a_wait_extend: assert property (s_last_wait ##0 (wait_ok && !WAIT_N) |=> st == EAD_TW)
		else $error("wait input ignored");
	a_wait_release: assert property (s_last_wait ##0 WAIT_N |=> st == EAD_T2)
		else $error("cycle not released");
	a_card_width: assert property (act && card |-> width != WID_32)
		else $error("card at longword width");
	a_dram2_width: assert property (act && area == AREA_2 && mtype == MEM_DRAM |->
		width == WID_16)
		else $error("area 2 dram not 16 bits");
	a_card_setup: assert property (st == EAD_SETUP && area == AREA_5 |->
		!STROBES.card_enable_low_n && STROBES.card_oe_n && STROBES.card_we_n)
		else $error("strobe inside card setup");

endmodule
`default_nettype wire

// ==== test/ead_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ead_mem_model
	import ead_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire ead_strobe_t STROBES,
	input wire logic [7:0] HOLD_LEN,
	output logic WAIT_N
);
	logic [7:0] cnt;
	logic sel;
	assign sel = ~&STROBES.area_select_n;
	// counts cycles since the select fell, so wait only moves just after clock edges
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !sel) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	// pulled up once the select is released
	assign WAIT_N = !(sel && cnt < HOLD_LEN);
endmodule
`default_nettype wire

// ==== test/tb_external_area_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_external_area_decoder
	import ead_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	ead_req_t req = '0;
	ead_cfg_t cfg = '0;
	logic [1:0] boot = 2'h3;
	logic [7:0] hold_len = 8'h00;
	logic wait_n, req_ready, beat_done, xfer_done, range_fault;
	ead_strobe_t strobes;
	logic [OFFSET_W-1:0] bus_addr;
	logic [1:0] bus_width;
	int errors = 0;
	int tests_run = 0;
	logic mon = 1'b0;
	logic [6:0] s_sel;
	logic [3:0] s_wr;
	logic s_rd, s_ce5, s_ce6, s_io, s_area2_row_strobe_n, s_ras, s_oer, s_flt;
	int s_cyc, s_selc, s_cec, s_beats;
	logic [1:0] s_wid;
	logic [OFFSET_W-1:0] s_row, s_addr;
	int wtab [8] = '{0, 1, 2, 3, 4, 6, 8, 10};

	always #10 clk_sys = ~clk_sys;

	ead_decoder #(.BURST_MIN_PITCH(2)) DUT (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req), .CFG(cfg),
		.BOOT_WIDTH_PIN_A(boot[0]), .BOOT_WIDTH_PIN_B(boot[1]), .WAIT_N(wait_n),
		.STROBES(strobes), .BUS_ADDR(bus_addr), .BUS_WIDTH(bus_width),
		.BEAT_DONE(beat_done), .XFER_DONE(xfer_done), .RANGE_FAULT(range_fault));

	ead_mem_model mem (.CLK_SYS(clk_sys), .RST_N(rst_n), .STROBES(strobes),
		.HOLD_LEN(hold_len), .WAIT_N(wait_n));

	always @(posedge clk_sys) begin
		if (mon) begin
			// first bus cycle carries the row address of a dram beat
			if (s_cyc == 0) begin
				s_row = bus_addr;
			end
			s_cyc++;
			s_sel |= ~strobes.area_select_n;
			s_selc += int'(~&strobes.area_select_n);
			s_cec += int'(!strobes.card_enable_low_n || !strobes.area6_card_enable_low_n);
			s_wr |= ~strobes.byte_write_strobe_n;
			s_rd |= !strobes.read_strobe_n;
			s_ce5 |= !strobes.card_enable_low_n;
			s_ce6 |= !strobes.area6_card_enable_low_n;
			s_io |= !strobes.card_io_read_n || !strobes.card_io_write_n;
			s_area2_row_strobe_n |= !strobes.area2_row_strobe_n;
			s_ras |= !strobes.row_strobe_n;
			s_oer |= !strobes.output_enable_refresh_n;
			s_wid = bus_width;
			s_addr = bus_addr;
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic [1:0] b);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		boot <= b;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
	endtask

	task automatic access(input logic [31:0] a, input logic w, input logic [1:0] sz,
		input ead_cfg_t c);
		int n;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= '{addr: a, write: w, size: sz};
		cfg <= c;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		mon <= 1'b1;
		{s_sel, s_wr, s_rd, s_ce5, s_ce6, s_io, s_area2_row_strobe_n, s_ras, s_oer, s_flt} = '0;
		{s_cyc, s_selc, s_cec, s_beats} = '0;
		for (n = 0; n < 300; n++) begin
			#1;
			s_beats += int'(beat_done);
			s_flt = range_fault;
			if (xfer_done === 1'b1) break;
			@(posedge clk_sys);
		end
		mon <= 1'b0;
		if (n == 300) begin
			errors++;
			final_report();
		end
	endtask

	task automatic t_reset();
		do_reset(2'h1);
		#1;
		chk(req_ready, 1'b1);
		chk(strobes.area_select_n, 7'h7f);
		chk(xfer_done, 1'b0);
		access(32'h0000_0000, 1'b1, SZ_LONG, '0);
		chk(s_wid, WID_8);
		chk(s_beats, 4);
		chk(s_wr, 4'h1);
		$display("test reset_boot done");
	endtask

	task automatic t_decode();
		logic [2:0] ar;
		do_reset(2'h3);
		for (int i = 0; i < 8; i++) begin
			ar = 3'(i);
			access({(i < 7) ? ar : 3'h1, ar, 26'h000_0100}, 1'b0, SZ_BYTE, '0);
			chk(s_sel, (i < 7) ? (7'h01 << i) : 7'h00);
			chk(s_rd, i < 7);
		end
		access(32'hE000_0000, 1'b1, SZ_WORD, '0);
		chk(s_wr, 4'h3);
		chk(s_wid, WID_32);
		$display("test decode done");
	endtask

	task automatic t_waits();
		ead_cfg_t c;
		for (int i = 0; i < 8; i++) begin
			c = '0;
			c.area0_wait_count = 3'(i);
			c.area4_wait_count = 3'(i);
			c.area12_wait_count = 2'(i);
			c.area3_wait_count = 2'(i);
			access(32'h0000_0010, 1'b0, SZ_BYTE, c);
			chk(s_selc, wtab[i] + 2);
			access(32'h1000_0010, 1'b0, SZ_BYTE, c);
			chk(s_selc, wtab[i] + 2);
			for (int a = 1; a < 4; a++) begin
				access({3'h0, 3'(a), 26'h000_0010}, 1'b0, SZ_BYTE, c);
				chk(s_selc, i % 4 + 2);
			end
		end
		$display("test waits done");
	endtask

	task automatic t_extwait();
		ead_cfg_t c;
		c = '0;
		c.area12_wait_count = 2'h2;
		c.area3_wait_count = 2'h1;
		hold_len <= 8'h02;
		access(32'h0400_0000, 1'b0, SZ_BYTE, c);
		chk(s_selc, 4);
		hold_len <= 8'h05;
		access(32'h0400_0000, 1'b0, SZ_BYTE, c);
		chk(s_selc, 7);
		hold_len <= 8'h03;
		access(32'h0C00_0000, 1'b0, SZ_BYTE, c);
		chk(s_selc, 5);
		hold_len <= 8'h00;
		$display("test external_wait done");
	endtask

	task automatic t_width();
		ead_cfg_t c;
		c = '0;
		c.area1_width_sel = WID_8;
		c.area4_width_sel = WID_16;
		access(32'h0400_0000, 1'b1, SZ_LONG, c);
		chk({s_wid, 4'(s_beats), s_wr}, {WID_8, 4'h4, 4'h1});
		chk(s_addr, 26'h000_0003);
		access(32'h1000_0000, 1'b1, SZ_LONG, c);
		chk({s_wid, 4'(s_beats), s_wr}, {WID_16, 4'h2, 4'h3});
		chk(s_addr, 26'h000_0002);
		$display("test width done");
	endtask

	task automatic t_dram();
		ead_cfg_t c;
		logic [1:0] w0;
		c = '0;
		c.area2_type = MEM_DRAM;
		c.area3_width_sel = WID_32;
		access(32'h0800_1200, 1'b0, SZ_WORD, c);
		chk({s_area2_row_strobe_n, s_wid}, {1'b1, WID_16});
		chk(s_row, 26'h000_0024);
		chk(s_addr, 26'h000_1200);
		access(32'h0C00_0000, 1'b0, SZ_LONG, c);
		chk({s_wid, 4'(s_beats)}, {WID_16, 4'h2});
		c = '0;
		c.area3_type = MEM_SDRAM;
		c.memctl_size_bit = 1'b1;
		access(32'h0C00_0000, 1'b0, SZ_LONG, c);
		chk({s_ras, s_wid}, {1'b1, WID_32});
		c.area3_type = MEM_PSRAM;
		c.memctl_size_bit = 1'b0;
		access(32'h0C00_0000, 1'b1, SZ_BYTE, c);
		chk({s_sel[3], s_wr != 4'h0}, 2'h3);
		access(32'h0C00_0000, 1'b0, SZ_BYTE, c);
		chk(s_oer, 1'b1);
		w0 = s_wid;
		c.memctl_size_bit = 1'b1;
		access(32'h0C00_0000, 1'b0, SZ_BYTE, c);
		chk({w0, s_wid}, {WID_16, WID_32});
		$display("test dram done");
	endtask

	task automatic t_cards();
		ead_cfg_t c;
		c = '0;
		c.area5_card = 1'b1;
		c.area5_width_sel = WID_32;
		// synchronous dram sits beside the card, so the card goes to area 5
		c.area3_type = MEM_SDRAM;
		c.memctl_size_bit = 1'b1;
		for (int k = 0; k < 4; k++) begin
			c.area5_setup_delay = 2'(k);
			c.area5_hold_delay = 2'(3 - k);
			access(32'h1400_0100, 1'b0, SZ_BYTE, c);
			chk(s_cec, 7);
			chk({s_ce5, s_sel[5]}, 2'h2);
			chk(s_wid != WID_32, 1'b1);
		end
		access(32'h1600_0000, 1'b0, SZ_BYTE, c);
		chk({s_flt, s_ce5, s_rd}, 3'h4);
		c = '0;
		c.area6_card = 1'b1;
		c.area6_width_sel = WID_16;
		access(32'h1800_0000, 1'b0, SZ_BYTE, c);
		chk({s_ce6, s_io}, 2'h2);
		access(32'h1A00_0000, 1'b0, SZ_BYTE, c);
		chk({s_ce6, s_io}, 2'h3);
		access(32'h1800_0000, 1'b1, SZ_BYTE, c);
		chk(s_wr[1], 1'b1);
		$display("test cards done");
	endtask

	task automatic t_burst();
		ead_cfg_t c;
		int w;
		c = '0;
		c.area0_burst_rom = 1'b1;
		for (int i = 0; i < 8; i += 3) begin
			c.area0_wait_count = 3'(i);
			w = wtab[i];
			access(32'h0000_0000, 1'b0, SZ_LINE, c);
			chk(s_beats, 4);
			chk(s_cyc, w + 2 + 3 * ((w > 2) ? w : 2));
		end
		$display("test burst done");
	endtask

	initial begin
		t_reset();
		t_decode();
		t_waits();
		t_extwait();
		t_width();
		t_dram();
		t_cards();
		t_burst();
		final_report();
	end
endmodule
`default_nettype wire
